// >>> verilog/cta_pkg.sv
// package: constants and types for the 4-bit cpu transfer/arith datapath
package cta_pkg;

	// widths
	localparam int CTA_DW = 4;
	localparam int CTA_IW = 10;
	localparam int CTA_PCW = 14;
	localparam int CTA_HALFW = 7;
	localparam int CTA_PTRW = 10;
	localparam int CTA_DEPTH = 8;
	localparam int CTA_IDXW = 3;

	// instruction classes, upper bits of the 10-bit word
	localparam logic [5:0] CTA_OP_XFER = 6'h00;
	localparam logic [5:0] CTA_OP_MISC = 6'h01;
	localparam logic [5:0] CTA_OP_LDA = 6'h02;
	localparam logic [5:0] CTA_OP_ADDI = 6'h03;
	localparam logic [1:0] CTA_PFX_LXY = 2'h3;
	localparam logic [2:0] CTA_PFX_TBL = 3'h4;

	// sub codes of CTA_OP_XFER, low nibble
	localparam logic [3:0] CTA_X_NOP = 4'h0;
	localparam logic [3:0] CTA_X_B_TO_ACC = 4'h1;
	localparam logic [3:0] CTA_X_ACC_TO_B = 4'h2;
	localparam logic [3:0] CTA_X_Y_TO_ACC = 4'h3;
	localparam logic [3:0] CTA_X_ACC_TO_Y = 4'h4;
	localparam logic [3:0] CTA_X_ACC_B_TO_E = 4'h5;
	localparam logic [3:0] CTA_X_E_TO_ACC_B = 4'h6;
	localparam logic [3:0] CTA_X_ACC_TO_PAGE_EXT = 4'h7;
	localparam logic [3:0] CTA_X_PAGE_EXT_TO_ACC = 4'h8;
	localparam logic [3:0] CTA_X_Z_TO_ACC = 4'h9;
	localparam logic [3:0] CTA_X_X_TO_ACC = 4'ha;
	localparam logic [3:0] CTA_X_INDEX_TO_ACC = 4'hb;
	localparam logic [3:0] CTA_X_ADD_MEM = 4'hc;
	localparam logic [3:0] CTA_X_ADD_MEM_CARRY = 4'hd;
	localparam logic [3:0] CTA_X_AND_MEM = 4'he;
	localparam logic [3:0] CTA_X_OR_MEM = 4'hf;

	// sub codes of CTA_OP_MISC
	localparam logic [3:0] CTA_M_SET_CARRY = 4'h0;
	localparam logic [3:0] CTA_M_RETURN_PLAIN = 4'h1;
	localparam logic [3:0] CTA_M_RETURN_SKIP = 4'h2;

	// wishbone register byte offsets
	localparam logic [7:0] CTA_REG_CTRL = 8'h00;
	localparam logic [7:0] CTA_REG_STATUS = 8'h04;
	localparam logic [7:0] CTA_REG_PC = 8'h08;
	localparam logic [7:0] CTA_REG_POINTER = 8'h0c;

	// control register fields
	localparam int CTA_CTRL_RUN = 0;
	localparam int CTA_CTRL_HIGH_EN = 1;
	localparam logic [1:0] CTA_CTRL_RESET = 2'h0;

	typedef enum logic [0:0] {
		CTA_EXEC = 1'b0,
		CTA_TBL = 1'b1
	} cta_phase_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cta_wb_req_s;

	typedef struct packed {
		cta_phase_e phase;
		logic [CTA_DW-1:0] acc;
		logic [CTA_DW-1:0] b;
		logic [7:0] e;
		logic [CTA_DW-1:0] x;
		logic [CTA_DW-1:0] y;
		logic [1:0] z;
		logic [2:0] page_ext;
		logic carry;
		logic skip;
		logic [CTA_HALFW-1:0] pc_high;
		logic [CTA_HALFW-1:0] pc_low;
		logic [CTA_IDXW-1:0] index;
		logic [CTA_DEPTH-1:0][CTA_PCW-1:0] stack;
		logic [1:0] ctrl;
		logic wb_ack;
		logic [31:0] wb_dat;
	} cta_state_s;

endpackage : cta_pkg

// >>> verilog/cta_datapath.sv
// module: cpu register set, transfers, accumulator arithmetic and skip
//
// What this block does
// - ram pointer is x, y, z concatenated
// - program counter: 7-bit page, 7-bit word
// - eight-entry return stack, index up push
// - skip nullifies next instruction, pc advances once
// - skipped table fetch or return: one cycle
// - b, y and accumulator single copies
// - e upper from b, lower from accumulator
// - b from e upper, accumulator from lower
// - page extension to/from accumulator low three
// - z into accumulator low two, upper cleared
// - x copied fully into accumulator
// - stack index into accumulator, bit three cleared
// - add, and, or with ram word
// - add with carry updates carry; set carry
// - add 4-bit immediate to accumulator
// - table fetch pushes pc, jumps to page
// - high bits enable loads page ext from rom
// - fetched word to b/accumulator, then pop pc
// - address operands carry 7-bit page number
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/100ps

module cta_datapath (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// program rom, read without latency
	output logic [cta_pkg::CTA_PCW-1:0] rom_addr,
	input wire logic [cta_pkg::CTA_IW-1:0] rom_data,
	// data ram, read without latency
	output logic [cta_pkg::CTA_PTRW-1:0] ram_addr,
	input wire logic [cta_pkg::CTA_DW-1:0] ram_rdata,
	// wishbone classic slave
	input wire cta_pkg::cta_wb_req_s wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o
);
	import cta_pkg::*;

	cta_state_s s_reg;
	cta_state_s s_next;

	////////////////////////////////////////////////////////////////////
	// decode

	logic run;
	logic fire;
	logic [5:0] op;
	logic [3:0] sub;
	logic is_xfer;
	logic is_misc;
	logic is_lxy;
	logic is_tbl;
	logic [4:0] add_sum;
	logic [4:0] addc_sum;
	logic [4:0] addi_sum;
	logic [CTA_IDXW-1:0] index_up;
	logic [CTA_HALFW-1:0] low_up;
	logic [CTA_PCW-1:0] pc_now;
	logic [31:0] status_word;
	logic wb_hit;

	assign run = s_reg.ctrl[CTA_CTRL_RUN];
	assign fire = run && s_reg.phase == CTA_EXEC && !s_reg.skip;
	assign op = rom_data[9:4];
	assign sub = rom_data[3:0];
	assign is_lxy = rom_data[9:8] == CTA_PFX_LXY;
	assign is_tbl = rom_data[9:7] == CTA_PFX_TBL;
	assign is_xfer = op == CTA_OP_XFER;
	assign is_misc = op == CTA_OP_MISC;
	assign add_sum = {1'b0, s_reg.acc} + {1'b0, ram_rdata};
	assign addc_sum = add_sum + {4'h0, s_reg.carry};
	assign addi_sum = {1'b0, s_reg.acc} + {1'b0, sub};
	assign index_up = s_reg.index + 3'h1;
	// next word stays within the page
	assign low_up = s_reg.pc_low + 7'h01;
	assign pc_now = {s_reg.pc_high, s_reg.pc_low};
	assign wb_hit = wb_req.cyc && wb_req.stb && !s_reg.wb_ack;
	assign status_word = {7'h00, s_reg.phase, s_reg.skip, s_reg.page_ext,
		s_reg.index, s_reg.carry, s_reg.e, s_reg.b, s_reg.acc};

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next = s_reg;
		// bus slave: ack one cycle after the strobe, dropped the next
		s_next.wb_ack = wb_hit;
		if (wb_hit) begin
			case (wb_req.adr)
				CTA_REG_CTRL: begin
					s_next.wb_dat = {30'h0, s_reg.ctrl};
					if (wb_req.we && wb_req.sel[0]) begin
						s_next.ctrl = wb_req.dat[1:0];
					end
				end
				CTA_REG_STATUS: begin
					s_next.wb_dat = status_word;
				end
				CTA_REG_PC: begin
					s_next.wb_dat = {18'h0, pc_now};
				end
				CTA_REG_POINTER: begin
					s_next.wb_dat = {22'h0, s_reg.x, s_reg.y, s_reg.z};
				end
				default: begin
					s_next.wb_dat = 32'h0;
				end
			endcase
		end
		if (run && s_reg.phase == CTA_TBL) begin
			// table word into b and accumulator, pop
			s_next.b = rom_data[7:4];
			s_next.acc = rom_data[3:0];
			s_next.pc_high = s_reg.stack[s_reg.index][13:7];
			s_next.pc_low = s_reg.stack[s_reg.index][6:0];
			s_next.index = s_reg.index - 3'h1;
			s_next.phase = CTA_EXEC;
			// page extension from rom bits 9, 8
			if (s_reg.ctrl[CTA_CTRL_HIGH_EN]) begin
				s_next.page_ext = {1'b0, rom_data[9:8]};
			end
		end else if (run && s_reg.skip) begin
			// nullify in place, pc moves by one
			// skipped table fetch or return takes one cycle
			s_next.skip = 1'b0;
			s_next.pc_low = low_up;
		end else if (fire) begin
			s_next.pc_low = low_up;
			if (is_tbl) begin
				// push return address, jump into table
				s_next.index = index_up;
				s_next.stack[index_up] = {s_reg.pc_high, low_up};
				s_next.pc_high = rom_data[6:0];
				s_next.pc_low = {s_reg.page_ext, s_reg.acc};
				s_next.phase = CTA_TBL;
			end else if (is_lxy) begin
				s_next.x = rom_data[7:4];
				s_next.y = rom_data[3:0];
			end else if (op == CTA_OP_LDA) begin
				s_next.acc = sub;
			end else if (op == CTA_OP_ADDI) begin
				// add immediate; overflow skips, carry kept
				s_next.acc = addi_sum[3:0];
				s_next.skip = addi_sum[4];
			end else if (is_misc) begin
				case (sub)
					CTA_M_SET_CARRY: begin
						s_next.carry = 1'b1;
					end
					CTA_M_RETURN_PLAIN, CTA_M_RETURN_SKIP: begin
						s_next.pc_high = s_reg.stack[s_reg.index][13:7];
						s_next.pc_low = s_reg.stack[s_reg.index][6:0];
						s_next.index = s_reg.index - 3'h1;
						s_next.skip = sub == CTA_M_RETURN_SKIP;
					end
					default: begin
						s_next.skip = 1'b0;
					end
				endcase
			end else if (is_xfer) begin
				// each transfer touches only its destinations
				case (sub)
					CTA_X_B_TO_ACC: begin
						s_next.acc = s_reg.b;
					end
					CTA_X_ACC_TO_B: begin
						s_next.b = s_reg.acc;
					end
					CTA_X_Y_TO_ACC: begin
						s_next.acc = s_reg.y;
					end
					CTA_X_ACC_TO_Y: begin
						s_next.y = s_reg.acc;
					end
					CTA_X_ACC_B_TO_E: begin
						s_next.e = {s_reg.b, s_reg.acc};
					end
					CTA_X_E_TO_ACC_B: begin
						s_next.b = s_reg.e[7:4];
						s_next.acc = s_reg.e[3:0];
					end
					CTA_X_ACC_TO_PAGE_EXT: begin
						s_next.page_ext = s_reg.acc[2:0];
					end
					CTA_X_PAGE_EXT_TO_ACC: begin
						s_next.acc = {s_reg.acc[3], s_reg.page_ext};
					end
					CTA_X_Z_TO_ACC: begin
						s_next.acc = {2'h0, s_reg.z};
					end
					CTA_X_X_TO_ACC: begin
						s_next.acc = s_reg.x;
					end
					CTA_X_INDEX_TO_ACC: begin
						s_next.acc = {1'b0, s_reg.index};
					end
					CTA_X_ADD_MEM: begin
						s_next.acc = add_sum[3:0];
					end
					// add with carry in and out
					CTA_X_ADD_MEM_CARRY: begin
						s_next.acc = addc_sum[3:0];
						s_next.carry = addc_sum[4];
					end
					CTA_X_AND_MEM: begin
						s_next.acc = s_reg.acc & ram_rdata;
					end
					CTA_X_OR_MEM: begin
						s_next.acc = s_reg.acc | ram_rdata;
					end
					default: begin
						s_next.acc = s_reg.acc;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.phase <= CTA_EXEC;
			s_reg.ctrl <= CTA_CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rom_addr = pc_now;
	assign ram_addr = {s_reg.x, s_reg.y, s_reg.z};
	assign wb_ack = s_reg.wb_ack;
	assign wb_dat_o = s_reg.wb_dat;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	logic x_b_to_acc;
	logic x_acc_b_to_e_register;
	logic x_amc;
	logic x_stack_index_to_acc;
	logic x_z;
	assign x_b_to_acc = fire && is_xfer && sub == CTA_X_B_TO_ACC;
	assign x_acc_b_to_e_register = fire && is_xfer && sub == CTA_X_ACC_B_TO_E;
	assign x_amc = fire && is_xfer && sub == CTA_X_ADD_MEM_CARRY;
	assign x_stack_index_to_acc = fire && is_xfer && sub == CTA_X_INDEX_TO_ACC;
	assign x_z = fire && is_xfer && sub == CTA_X_Z_TO_ACC;

	a_pointer_concat: assert property (
		fire && is_lxy |=> ram_addr[9:2] == $past(rom_data[7:0])
		&& ram_addr[1:0] == $past(s_reg.z))
		else $error("ram pointer not x,y,z");

	a_table_two_cycles: assert property (
		fire && is_tbl |=> s_reg.phase == CTA_TBL
		&& rom_addr[13:7] == $past(rom_data[6:0])
		##1 s_reg.phase == CTA_EXEC)
		else $error("table fetch sequence wrong");

	a_table_index: assert property (
		fire && is_tbl |=> s_reg.index == $past(s_reg.index) + 3'h1
		##1 s_reg.index == $past(s_reg.index, 2))
		else $error("table fetch stack index wrong");

	a_skip_nullify: assert property (
		run && s_reg.phase == CTA_EXEC && s_reg.skip
		|=> s_reg.acc == $past(s_reg.acc) && !s_reg.skip
		&& s_reg.pc_low == $past(s_reg.pc_low) + 7'h01
		&& s_reg.phase == CTA_EXEC)
		else $error("skipped instruction not nullified");

	a_b_to_acc: assert property (
		x_b_to_acc |=> s_reg.acc == $past(s_reg.b)
		&& s_reg.b == $past(s_reg.b))
		else $error("b to accumulator copy wrong");

	a_e_from_acc_b: assert property (
		x_acc_b_to_e_register |=> s_reg.e == {$past(s_reg.b), $past(s_reg.acc)})
		else $error("e register load wrong");

	a_add_carry: assert property (
		x_amc |=> {s_reg.carry, s_reg.acc} == {1'b0, $past(s_reg.acc)}
		+ {1'b0, $past(ram_rdata)} + {4'h0, $past(s_reg.carry)})
		else $error("add with carry wrong");

	a_index_to_acc: assert property (
		x_stack_index_to_acc |=> s_reg.acc == {1'b0, $past(s_reg.index)})
		else $error("stack index copy wrong");

	a_z_to_acc: assert property (
		x_z |=> s_reg.acc[3:2] == 2'h0 && s_reg.acc[1:0] == $past(s_reg.z))
		else $error("z copy wrong");

	a_bus_ack_pulse: assert property (
		s_reg.wb_ack |=> !s_reg.wb_ack)
		else $error("ack held two cycles");

	a_halt_freeze: assert property (
		!run |=> $stable(pc_now) && $stable(s_reg.acc))
		else $error("halted core moved");

	a_e_to_acc_b: assert property (
		fire && is_xfer && sub == CTA_X_E_TO_ACC_B
		|=> s_reg.b == $past(s_reg.e[7:4])
		&& s_reg.acc == $past(s_reg.e[3:0]))
		else $error("b, accumulator load from e wrong");

	a_acc_to_page: assert property (
		fire && is_xfer && sub == CTA_X_ACC_TO_PAGE_EXT
		|=> s_reg.page_ext == $past(s_reg.acc[2:0]))
		else $error("page extension load wrong");

	a_page_to_acc: assert property (
		fire && is_xfer && sub == CTA_X_PAGE_EXT_TO_ACC
		|=> s_reg.acc[2:0] == $past(s_reg.page_ext)
		&& s_reg.acc[3] == $past(s_reg.acc[3]))
		else $error("page extension read wrong");

	a_x_to_acc: assert property (
		fire && is_xfer && sub == CTA_X_X_TO_ACC
		|=> s_reg.acc == $past(s_reg.x))
		else $error("x copy wrong");

	a_and_mem: assert property (
		fire && is_xfer && sub == CTA_X_AND_MEM
		|=> s_reg.acc == ($past(s_reg.acc) & $past(ram_rdata)))
		else $error("and with ram word wrong");

	a_or_mem: assert property (
		fire && is_xfer && sub == CTA_X_OR_MEM
		|=> s_reg.acc == ($past(s_reg.acc) | $past(ram_rdata)))
		else $error("or with ram word wrong");

	a_add_imm: assert property (
		fire && op == CTA_OP_ADDI
		|=> {s_reg.skip, s_reg.acc} == {1'b0, $past(s_reg.acc)}
		+ {1'b0, $past(sub)} && s_reg.carry == $past(s_reg.carry))
		else $error("add immediate wrong");

	a_lda_imm: assert property (
		fire && op == CTA_OP_LDA |=> s_reg.acc == $past(sub))
		else $error("immediate accumulator load wrong");

	a_table_word: assert property (
		run && s_reg.phase == CTA_TBL
		|=> s_reg.b == $past(rom_data[7:4])
		&& s_reg.acc == $past(rom_data[3:0]))
		else $error("table word not loaded");

	a_table_page: assert property (
		run && s_reg.phase == CTA_TBL && s_reg.ctrl[CTA_CTRL_HIGH_EN]
		|=> s_reg.page_ext == {1'b0, $past(rom_data[9:8])})
		else $error("table page extension wrong");

	a_skip_table: assert property (
		run && s_reg.skip && is_tbl
		|=> s_reg.phase == CTA_EXEC
		&& s_reg.index == $past(s_reg.index))
		else $error("skipped table fetch not one cycle");

	a_write_lands: assert property (
		s_reg.wb_ack && $past(wb_req.we && wb_req.sel[0]
		&& wb_req.adr == CTA_REG_CTRL)
		|-> s_reg.ctrl == $past(wb_req.dat[1:0]))
		else $error("control write lost");

endmodule : cta_datapath

// >>> tb/cta_mem_model.sv
// partner model: combinational program rom and data ram
`timescale 1ns/100ps

module cta_mem_model (
	// program rom
	input wire logic [cta_pkg::CTA_PCW-1:0] rom_addr,
	output logic [cta_pkg::CTA_IW-1:0] rom_data,
	// data ram
	input wire logic [cta_pkg::CTA_PTRW-1:0] ram_addr,
	output logic [cta_pkg::CTA_DW-1:0] ram_rdata
);
	import cta_pkg::*;
	logic [CTA_IW-1:0] rom [0:16383];
	logic [CTA_DW-1:0] ram [0:1023];
	initial begin
		for (int i = 0; i < 16384; i++) begin
			rom[i] = 10'h000;
		end
		// word mirrors the y field, so a wrong pointer shows in sums
		for (int i = 0; i < 1024; i++) begin
			ram[i] = 4'(i >> 2);
		end
	end
	assign rom_data = rom[rom_addr];
	assign ram_rdata = ram[ram_addr];
endmodule : cta_mem_model

// >>> tb/tb_top.sv
// testbench: program run on the datapath, read back over wishbone
`timescale 1ns/100ps

module tb_top;
	import cta_pkg::*;
	logic clock;
	logic srst;
	cta_wb_req_s wb_req;
	logic wb_ack;
	logic [31:0] wb_dat_o;
	logic [CTA_PCW-1:0] rom_addr;
	logic [CTA_IW-1:0] rom_data;
	logic [CTA_PTRW-1:0] ram_addr;
	logic [CTA_DW-1:0] ram_rdata;
	int miscompares = 0;
	int total_checks = 0;
	int cyc_count = 0;
	int ts [int];
	logic [31:0] rd;
	localparam logic [9:0] prog [0:28] = '{
		10'h359, 10'h027, 10'h002, 10'h023, 10'h005, 10'h03f,
		10'h02a, 10'h00c, 10'h010, 10'h00d, 10'h006, 10'h00f,
		10'h00e, 10'h007, 10'h024, 10'h202, 10'h03f, 10'h202,
		10'h003, 10'h02c, 10'h004, 10'h00a, 10'h002, 10'h008,
		10'h02f, 10'h00b, 10'h02f, 10'h009, 10'h001};

	////////////////////////////////////////////////////////////////////////
	cta_datapath i_dut (
		.clock(clock),
		.srst(srst),
		.rom_addr(rom_addr),
		.rom_data(rom_data),
		.ram_addr(ram_addr),
		.ram_rdata(ram_rdata),
		.wb_req(wb_req),
		.wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o)
	);
	cta_mem_model i_mem (
		.rom_addr(rom_addr),
		.rom_data(rom_data),
		.ram_addr(ram_addr),
		.ram_rdata(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// first cycle each fetch address appears; later wraps are ignored
	always @(posedge clock) begin
		cyc_count <= cyc_count + 1;
		if (!srst && !ts.exists(int'(rom_addr))) begin
			ts[int'(rom_addr)] = cyc_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [3:0] sel, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clock);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		q = wb_dat_o;
		wb_req <= '0;
	endtask : wb

	task automatic complete_run();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		wb_req = '0;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		// program loaded while the core is still halted
		for (int i = 0; i < 29; i++) begin
			i_mem.rom[i] = prog[i];
		end
		i_mem.rom[14'h114] = 10'h2a6;
		wb(1'b0, CTA_REG_CTRL, 4'hf, 32'h0, rd);
		chk(rd, 32'h0);
		wb(1'b0, CTA_REG_PC, 4'hf, 32'h0, rd);
		chk(rd, 32'h0);
		wb(1'b1, CTA_REG_CTRL, 4'h0, 32'h3, rd);
		wb(1'b0, CTA_REG_CTRL, 4'hf, 32'h0, rd);
		chk(rd, 32'h0);
		wb(1'b0, 8'h10, 4'hf, 32'h0, rd);
		chk(rd, 32'h0);
		// run with high bits enabled; 40 cycles stay in page 0 except the table word fetched from page 2
		wb(1'b1, CTA_REG_CTRL, 4'hf, 32'h3, rd);
		repeat (40) @(posedge clock);
		wb(1'b1, CTA_REG_CTRL, 4'hf, 32'h0, rd);
		wb(1'b0, CTA_REG_STATUS, 4'hf, 32'h0, rd);
		chk(rd, 32'h0021_7355);
		chk({28'h0, rd[3:0]}, 32'h5);
		chk({28'h0, rd[15:12]}, 32'h7);
		chk({29'h0, rd[22:20]}, 32'h2);
		chk({29'h0, rd[19:17]}, 32'h0);
		chk({31'h0, rd[16]}, 32'h1);
		wb(1'b0, CTA_REG_POINTER, 4'hf, 32'h0, rd);
		chk(rd, 32'h170);
		chk(32'(ts[15] - ts[1]), 32'd14);
		chk(32'(ts[7] - ts[5]), 32'd2);
		chk(32'(ts[int'(14'h114)] - ts[15]), 32'd1);
		chk(32'(ts[16] - ts[15]), 32'd2);
		chk(32'(ts[18] - ts[16]), 32'd2);
		chk(32'(ts[23] - ts[18]), 32'd5);
		chk(32'(ts[28] - ts[23]), 32'd5);
		complete_run();
	end

	initial begin
		repeat (2000) @(posedge clock);
		miscompares++;
		complete_run();
	end
endmodule : tb_top
